/* File: fmpc_pkg.sv */
// shared constants and types for the flash map and program control
package fmpc_pkg;
  // flash control register and its fields
  localparam logic [7:0]  FLASH_CONTROL_ADDR = 8'hd1;
  localparam logic [7:0]  FLASH_CONTROL_RST  = 8'h00;
  localparam int          LAUNCH_HI          = 7;
  localparam int          LAUNCH_LO          = 4;
  localparam int          LATCH_MAP_POS      = 3;
  localparam int          SPACE_HI           = 2;
  localparam int          SPACE_LO           = 1;
  localparam int          BUSY_POS           = 0;
  localparam logic [3:0]  UNLOCK_FIRST       = 4'h5;
  localparam logic [3:0]  UNLOCK_SECOND      = 4'ha;
  localparam logic [1:0]  SPACE_USER         = 2'h0;
  localparam logic [1:0]  SPACE_XROW         = 2'h1;
  localparam logic [1:0]  SPACE_SECURITY     = 2'h2;
  localparam logic [1:0]  SPACE_RESERVED     = 2'h3;
  // address map
  localparam logic [15:0] USER_TOP           = 16'h3fff;
  localparam logic [15:0] XROW_BASE          = 16'hff80;
  localparam logic [15:0] BOOT_BASE          = 16'hf800;
  localparam int          PAGE_BYTES         = 128;
  localparam int          USER_BYTES         = 16384;
  localparam logic [6:0]  LAST_INDEX         = 7'h7f;
  localparam logic [7:0]  ERASED             = 8'hff;
  // security byte: bit0 lock zero, bit1 lock one, bit2 lock two (0 = programmed)
  localparam logic [7:0]  SECURITY_RST       = 8'hfd;
  localparam logic [7:0]  SECURITY_SW_MASK   = 8'hf0;
  // controller command registers
  localparam logic [2:0]  HOST_CMD           = 3'h0;
  localparam logic [2:0]  HOST_ADDR          = 3'h1;
  localparam logic [2:0]  HOST_DATA          = 3'h2;
  localparam logic [2:0]  HOST_CTRL          = 3'h3;
  localparam logic [2:0]  HOST_RESULT        = 3'h4;
  localparam logic [2:0]  HOST_STATUS        = 3'h5;
  localparam int          CTRL_FROM_BOOT     = 0;
  localparam int          CTRL_BOOT_MAP      = 1;
  localparam int          CTRL_EEPROM_MAP    = 2;
  localparam logic [2:0]  OP_SFR_WRITE       = 3'h0;
  localparam logic [2:0]  OP_SFR_READ        = 3'h1;
  localparam logic [2:0]  OP_DATA_WRITE      = 3'h2;
  localparam logic [2:0]  OP_CODE_READ       = 3'h3;
  localparam logic [2:0]  OP_OTHER           = 3'h4;
  typedef enum logic [1:0] {FMPC_IDLE, FMPC_ERASE, FMPC_PROG} fmpc_state_t;
endpackage

/* File: fmpc_if.sv */
// link between the cpu side and the flash control end
`timescale 1ns/10ps
`default_nettype none
interface fmpc_if;
  logic        instr_step;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        data_wr;
  logic [15:0] data_addr;
  logic [7:0]  data_wdata;
  logic        code_rd;
  logic [15:0] code_addr;
  logic [7:0]  code_rdata;
  logic        code_boot_hit;
  logic        from_boot;
  logic        boot_map_enable;
  logic        eeprom_map_bit;
  modport cpu (
    output instr_step, sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
    output data_wr, data_addr, data_wdata, code_rd, code_addr,
    output from_boot, boot_map_enable, eeprom_map_bit,
    input  sfr_rdata, code_rdata, code_boot_hit
  );
  modport flash (
    input  instr_step, sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
    input  data_wr, data_addr, data_wdata, code_rd, code_addr,
    input  from_boot, boot_map_enable, eeprom_map_bit,
    output sfr_rdata, code_rdata, code_boot_hit
  );
endinterface
`default_nettype wire

/* File: fmpc_flash_end.sv */
// flash map, column latch and program sequencer end
//
// Operation
// - latch map steers data writes into latches
// - latch map overrides eeprom map
// - space select picks code read space
// - default: code reads only, no writes
// - 5x then Ax launches; reserved does nothing
// - any instruction between unlock writes aborts
// - 50h A0h programs the user page
// - 52h A2h programs the extra row
// - software writes 0Ch, byte, 54h A4h
// - launch code runs from boot flash
// - busy bit hardware owned, software-proof
// - boot map enable maps boot flash high
// - latches accept 1 to 128 bytes
// - erase loaded bytes, then program them
// - last loaded page address is programmed
// - software keeps interrupts off meanwhile
// - software maps 02h/04h for reads, clears
// - software clears control register when idle
// - lock bits give four security levels
// - lock bits only parallel-written, default three
// - control register resets to zero, fixed layout
// - no user array program from user flash
`timescale 1ns/10ps
`default_nettype none
module fmpc_flash_end
  import fmpc_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // link to the cpu side
  fmpc_if.flash     bus,
  // status toward the rest of the chip
  output logic      program_busy_flag,
  output logic      eeprom_select,
  output logic      parallel_prog_disable,
  output logic      parallel_verify_disable
);

  // control register fields and sequencer state
  logic [3:0]  launch_command_field;
  logic        latch_map_bit;
  logic [1:0]  space_select_field;
  logic        armed;
  logic [7:0]  page;
  logic [PAGE_BYTES-1:0] loaded;
  logic [1:0]  prog_space;
  logic [6:0]  idx;
  fmpc_state_t state;
  logic [7:0]  sec_byte;
  logic [7:0]  sfr_rdata;
  logic [7:0]  code_rdata;
  logic        code_boot_hit;

  logic [3:0]  next_launch_command_field;
  logic        next_latch_map_bit;
  logic [1:0]  next_space_select_field;
  logic        next_armed;
  logic [7:0]  next_page;
  logic [PAGE_BYTES-1:0] next_loaded;
  logic [1:0]  next_prog_space;
  logic [6:0]  next_idx;
  fmpc_state_t next_state;
  logic [7:0]  next_sec_byte;
  logic [7:0]  next_sfr_rdata;
  logic [7:0]  next_code_rdata;
  logic        next_code_boot_hit;

  // storage arrays
  logic [7:0]  latch_data [PAGE_BYTES];
  logic [7:0]  user_mem [USER_BYTES];
  logic [7:0]  xrow_mem [PAGE_BYTES];

  // decoded strobes
  logic        ctl_wr;
  logic        busy;
  logic        latch_wr;
  logic        launch;
  logic [3:0]  wr_nibble;
  logic [1:0]  wr_space;
  logic [13:0] cell_addr;
  logic        cell_wr;
  logic [7:0]  cell_data;
  logic        xrow_wr;

  // access decode
  always_comb begin
    busy      = (state != FMPC_IDLE);
    ctl_wr    = bus.sfr_wr && (bus.sfr_addr == FLASH_CONTROL_ADDR);
    wr_nibble = bus.sfr_wdata[LAUNCH_HI:LAUNCH_LO];
    wr_space  = bus.sfr_wdata[SPACE_HI:SPACE_LO];
    // writes reach latches only while mapped, in user or extra row window
    latch_wr  = bus.data_wr && latch_map_bit && !busy
                && ((bus.data_addr <= USER_TOP) || (bus.data_addr >= XROW_BASE));
    launch    = ctl_wr && armed && (wr_nibble == UNLOCK_SECOND) && !busy
                && (wr_space != SPACE_RESERVED)
                && ((wr_space != SPACE_USER) || bus.from_boot);
  end

  // eeprom controller sees its map only when latches do not claim the bus
  assign eeprom_select = bus.eeprom_map_bit && !latch_map_bit;

  // register, unlock and latch bookkeeping
  always_comb begin
    next_launch_command_field = launch_command_field;
    next_latch_map_bit        = latch_map_bit;
    next_space_select_field   = space_select_field;
    next_armed                = armed;
    next_page                 = page;
    next_loaded               = loaded;
    next_prog_space           = prog_space;
    next_idx                  = idx;
    next_state                = state;
    next_sec_byte             = sec_byte;
    if (ctl_wr) begin
      // busy bit is not writable
      next_launch_command_field = wr_nibble;
      next_latch_map_bit        = bus.sfr_wdata[LATCH_MAP_POS];
      next_space_select_field   = wr_space;
      next_armed                = (wr_nibble == UNLOCK_FIRST) && !busy;
    end else if (bus.instr_step) begin
      next_armed = 1'b0;
    end
    if (latch_wr) begin
      next_page = bus.data_addr[14:7];
      next_loaded[bus.data_addr[6:0]] = 1'b1;
    end
    unique case (state)
      FMPC_IDLE: begin
        if (launch) begin
          next_prog_space = wr_space;
          next_idx        = 7'h00;
          next_state      = FMPC_ERASE;
        end
      end
      FMPC_ERASE: begin
        next_idx = idx + 7'h01;
        if (idx == LAST_INDEX) begin
          next_state = FMPC_PROG;
        end
      end
      FMPC_PROG: begin
        next_idx = idx + 7'h01;
        if ((prog_space == SPACE_SECURITY) && (idx == 7'h00) && loaded[0]) begin
          // only the software nibble; lock bits stay as they are
          next_sec_byte = (latch_data[0] & SECURITY_SW_MASK)
                          | (sec_byte & ~SECURITY_SW_MASK);
        end
        if (idx == LAST_INDEX) begin
          next_loaded = '0;
          next_state  = FMPC_IDLE;
        end
      end
    endcase
  end

  // cell write path for the sequencer
  always_comb begin
    cell_addr = {page[6:0], idx};
    cell_data = (state == FMPC_ERASE) ? ERASED : latch_data[idx];
    cell_wr   = busy && loaded[idx] && (prog_space == SPACE_USER);
    xrow_wr   = busy && loaded[idx] && (prog_space == SPACE_XROW);
  end

  // register read and code space read
  always_comb begin
    next_sfr_rdata     = 8'h00;
    next_code_rdata    = 8'h00;
    next_code_boot_hit = 1'b0;
    if (bus.sfr_rd && (bus.sfr_addr == FLASH_CONTROL_ADDR)) begin
      next_sfr_rdata = {launch_command_field, latch_map_bit,
                        space_select_field, busy};
    end
    if (bus.code_rd) begin
      unique case (space_select_field)
        SPACE_XROW: begin
          next_code_rdata = xrow_mem[bus.code_addr[6:0]];
        end
        SPACE_SECURITY: begin
          next_code_rdata = sec_byte;
        end
        default: begin
          if (bus.boot_map_enable && (bus.code_addr >= BOOT_BASE)) begin
            next_code_boot_hit = 1'b1;
          end else if (bus.code_addr <= USER_TOP) begin
            next_code_rdata = user_mem[bus.code_addr[13:0]];
          end
        end
      endcase
    end
  end

  // security level decode, lock bit 0 lowest
  always_comb begin
    parallel_prog_disable   = !(sec_byte[0] && sec_byte[1] && sec_byte[2]);
    parallel_verify_disable = !sec_byte[1] || !sec_byte[2];
  end

  // control state registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      launch_command_field <= FLASH_CONTROL_RST[LAUNCH_HI:LAUNCH_LO];
      latch_map_bit        <= FLASH_CONTROL_RST[LATCH_MAP_POS];
      space_select_field   <= FLASH_CONTROL_RST[SPACE_HI:SPACE_LO];
      armed                <= 1'b0;
      page                 <= 8'h00;
      loaded               <= '0;
      prog_space           <= SPACE_USER;
      idx                  <= 7'h00;
      state                <= FMPC_IDLE;
      sec_byte             <= SECURITY_RST;
      sfr_rdata            <= 8'h00;
      code_rdata           <= 8'h00;
      code_boot_hit        <= 1'b0;
    end else begin
      launch_command_field <= next_launch_command_field;
      latch_map_bit        <= next_latch_map_bit;
      space_select_field   <= next_space_select_field;
      armed                <= next_armed;
      page                 <= next_page;
      loaded               <= next_loaded;
      prog_space           <= next_prog_space;
      idx                  <= next_idx;
      state                <= next_state;
      sec_byte             <= next_sec_byte;
      sfr_rdata            <= next_sfr_rdata;
      code_rdata           <= next_code_rdata;
      code_boot_hit        <= next_code_boot_hit;
    end
  end

  // array writes, contents are not reset
  always_ff @(posedge mclk) begin
    if (latch_wr) begin
      latch_data[bus.data_addr[6:0]] <= bus.data_wdata;
    end
    if (cell_wr) begin
      user_mem[cell_addr] <= cell_data;
    end
    if (xrow_wr) begin
      xrow_mem[idx] <= cell_data;
    end
  end

  assign bus.sfr_rdata     = sfr_rdata;
  assign bus.code_rdata    = code_rdata;
  assign bus.code_boot_hit = code_boot_hit;
  assign program_busy_flag = busy;

endmodule
`default_nettype wire

/* File: fmpc_cpu_end.sv */
// cpu side end: issues register, data and code accesses on command
`timescale 1ns/10ps
`default_nettype none
module fmpc_cpu_end
  import fmpc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // command port
  input  wire logic [2:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic      [15:0] cmd_rdata,
  // link to the flash end
  fmpc_if.cpu              bus
);

  logic [15:0] addr;
  logic [7:0]  data;
  logic [2:0]  ctrl;
  logic [7:0]  result;
  logic        pending;
  logic [2:0]  op;
  logic        fire;
  logic        capture;
  logic [15:0] cmd_rdata_q;

  logic [15:0] next_addr;
  logic [7:0]  next_data;
  logic [2:0]  next_ctrl;
  logic [7:0]  next_result;
  logic        next_pending;
  logic [2:0]  next_op;
  logic        next_fire;
  logic        next_capture;
  logic [15:0] next_cmd_rdata;

  // command decode, one access per command
  always_comb begin
    next_addr      = addr;
    next_data      = data;
    next_ctrl      = ctrl;
    next_result    = result;
    next_op        = op;
    next_fire      = 1'b0;
    next_capture   = fire && ((op == OP_SFR_READ) || (op == OP_CODE_READ));
    next_pending   = pending;
    next_cmd_rdata = 16'h0000;
    if (capture) begin
      next_result  = (op == OP_SFR_READ) ? bus.sfr_rdata : bus.code_rdata;
      next_pending = 1'b0;
    end else if (fire && !next_capture) begin
      next_pending = 1'b0;
    end
    if (cmd_wr) begin
      unique case (cmd_addr)
        HOST_CMD: begin
          next_op      = cmd_wdata[2:0];
          next_fire    = 1'b1;
          next_pending = 1'b1;
        end
        HOST_ADDR: next_addr = cmd_wdata;
        HOST_DATA: next_data = cmd_wdata[7:0];
        HOST_CTRL: next_ctrl = cmd_wdata[2:0];
        default: begin
        end
      endcase
    end
    if (cmd_rd) begin
      unique case (cmd_addr)
        HOST_ADDR:   next_cmd_rdata = addr;
        HOST_DATA:   next_cmd_rdata = {8'h00, data};
        HOST_CTRL:   next_cmd_rdata = {13'h0000, ctrl};
        HOST_RESULT: next_cmd_rdata = {8'h00, result};
        HOST_STATUS: next_cmd_rdata = {15'h0000, pending};
        default:     next_cmd_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      addr        <= 16'h0000;
      data        <= 8'h00;
      ctrl        <= 3'h0;
      result      <= 8'h00;
      pending     <= 1'b0;
      op          <= OP_OTHER;
      fire        <= 1'b0;
      capture     <= 1'b0;
      cmd_rdata_q <= 16'h0000;
    end else begin
      addr        <= next_addr;
      data        <= next_data;
      ctrl        <= next_ctrl;
      result      <= next_result;
      pending     <= next_pending;
      op          <= next_op;
      fire        <= next_fire;
      capture     <= next_capture;
      cmd_rdata_q <= next_cmd_rdata;
    end
  end

  // every access counts as one instruction for the unlock guard
  assign bus.instr_step      = fire;
  assign bus.sfr_wr          = fire && (op == OP_SFR_WRITE);
  assign bus.sfr_rd          = fire && (op == OP_SFR_READ);
  assign bus.data_wr         = fire && (op == OP_DATA_WRITE);
  assign bus.code_rd         = fire && (op == OP_CODE_READ);
  assign bus.sfr_addr        = addr[7:0];
  assign bus.sfr_wdata       = data;
  assign bus.data_addr       = addr;
  assign bus.data_wdata      = data;
  assign bus.code_addr       = addr;
  assign bus.from_boot       = ctrl[CTRL_FROM_BOOT];
  assign bus.boot_map_enable = ctrl[CTRL_BOOT_MAP];
  assign bus.eeprom_map_bit  = ctrl[CTRL_EEPROM_MAP];
  assign cmd_rdata           = cmd_rdata_q;

endmodule
`default_nettype wire

/* File: fmpc_chk.sv */
// checker for the link between the cpu end and the flash end
`timescale 1ns/10ps
`default_nettype none
module fmpc_chk
  import fmpc_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // link signals
  input wire logic       instr_step,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       code_rd,
  input wire logic [7:0] code_rdata,
  input wire logic       code_boot_hit,
  input wire logic       from_boot,
  input wire logic       boot_map_enable,
  // flash end status
  input wire logic       program_busy_flag
);
  logic       ctl_wr;
  logic       five_wr;
  logic       ten_wr;
  logic       armed;
  logic [8:0] busy_cnt;
  // control register writes by launch nibble
  assign ctl_wr  = sfr_wr && (sfr_addr == FLASH_CONTROL_ADDR);
  assign five_wr = ctl_wr && (sfr_wdata[7:4] == UNLOCK_FIRST);
  assign ten_wr  = ctl_wr && (sfr_wdata[7:4] == UNLOCK_SECOND);
  // previous instruction was a first unlock write; counts busy cycles
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      armed    <= 1'b0;
      busy_cnt <= 9'h000;
    end else begin
      if (instr_step) begin
        armed <= five_wr && !program_busy_flag;
      end
      busy_cnt <= program_busy_flag ? busy_cnt + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_SFR_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("register read data not zero outside answer cycle");
  AST_CODE_IDLE: assert property (!code_rd |=> code_rdata == 8'h00 && !code_boot_hit)
    else $error("code answer outside answer cycle");
  AST_BUSY_READBACK: assert property (sfr_rd && sfr_addr == FLASH_CONTROL_ADDR
    |=> sfr_rdata[0] == $past(program_busy_flag)) else $error("busy bit readback wrong");
  AST_LAUNCH: assert property (ten_wr && armed && !program_busy_flag
    && sfr_wdata[2:1] != SPACE_RESERVED && (sfr_wdata[2:1] != SPACE_USER || from_boot)
    |=> program_busy_flag) else $error("unlock pair did not start programming");
  AST_NO_STRAY: assert property (!program_busy_flag && !(ten_wr && armed)
    |=> !program_busy_flag) else $error("programming started without unlock pair");
  AST_RESERVED: assert property (ten_wr && sfr_wdata[2:1] == SPACE_RESERVED
    && !program_busy_flag |=> !program_busy_flag) else $error("reserved space launched");
  AST_USER_BOOT: assert property (ten_wr && sfr_wdata[2:1] == SPACE_USER && !from_boot
    && !program_busy_flag |=> !program_busy_flag) else $error("user launch from user flash");
  AST_BUSY_LEN: assert property ($fell(program_busy_flag) |-> busy_cnt == 9'd256)
    else $error("busy period length wrong");
  AST_BUSY_BOUND: assert property (busy_cnt <= 9'd256)
    else $error("busy held too long");
  AST_BOOT_OFF: assert property (code_rd && !boot_map_enable |=> !code_boot_hit)
    else $error("boot flash hit while unmapped");
  // main scenarios
  cover property ($rose(program_busy_flag));
  cover property ($fell(program_busy_flag));
  cover property (ten_wr && !armed);
  cover property (code_rd ##1 code_boot_hit);
endmodule
`default_nettype wire

/* File: flash_map_program_control_tb.sv */
// self-checking bench for both ends joined by the link
`timescale 1ns/10ps
`default_nettype none
module flash_map_program_control_tb;
  import fmpc_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  cmd_addr = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        cmd_wr = 1'b0;
  logic        cmd_rd = 1'b0;
  logic [15:0] cmd_rdata;
  logic        program_busy_flag;
  logic        eeprom_select;
  logic        parallel_prog_disable;
  logic        parallel_verify_disable;
  int          num_errors = 0;
  int          checks_done = 0;
  int          seed = 50030;
  logic [15:0] exp_q [$];
  string       name_q [$];
  logic        rd_pend = 1'b0;
  logic        hit_seen = 1'b0;
  logic [7:0]  v [4];
  logic [15:0] ra [4] = '{16'h0381, 16'h0383, 16'h0380, 16'h03ff};
  logic [7:0]  f1 [5] = '{8'h50, 8'h30, 8'ha0, 8'h56, 8'h50};
  logic [7:0]  f2 [5] = '{8'ha0, 8'ha0, 8'ha0, 8'ha6, 8'ha0};
  fmpc_if bus_if ();
  fmpc_cpu_end fmpc_cpu_end_inst (.mclk(mclk), .nrst(nrst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .bus(bus_if.cpu));
  fmpc_flash_end fmpc_flash_end_inst (.mclk(mclk), .nrst(nrst), .bus(bus_if.flash),
    .program_busy_flag(program_busy_flag), .eeprom_select(eeprom_select),
    .parallel_prog_disable(parallel_prog_disable),
    .parallel_verify_disable(parallel_verify_disable));
  fmpc_chk fmpc_chk_inst (.mclk(mclk), .nrst(nrst), .instr_step(bus_if.instr_step),
    .sfr_wr(bus_if.sfr_wr), .sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr),
    .sfr_wdata(bus_if.sfr_wdata), .sfr_rdata(bus_if.sfr_rdata), .code_rd(bus_if.code_rd),
    .code_rdata(bus_if.code_rdata), .code_boot_hit(bus_if.code_boot_hit),
    .from_boot(bus_if.from_boot), .boot_map_enable(bus_if.boot_map_enable),
    .program_busy_flag(program_busy_flag));
  // clock
  always #2.5 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one command port cycle, write or read
  task automatic host(input logic w, input logic [2:0] a, input logic [15:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= w;
    cmd_rd <= !w;
    @(posedge mclk);
  endtask
  task automatic idle(input int n);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  // one link instruction through the command registers
  task automatic op(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d);
    host(1'b1, HOST_ADDR, a);
    host(1'b1, HOST_DATA, {8'h00, d});
    host(1'b1, HOST_CMD, {13'h0000, o});
  endtask
  task automatic ctl(input logic [7:0] d);
    op(OP_SFR_WRITE, {8'h00, FLASH_CONTROL_ADDR}, d);
  endtask
  // issue a read and note the answer expected from the result register
  task automatic expect_rd(input string what, input logic [2:0] o, input logic [15:0] a,
                           input logic [7:0] e);
    op(o, a, 8'h00);
    idle(3);
    exp_q.push_back({8'h00, e});
    name_q.push_back(what);
    host(1'b0, HOST_RESULT, 16'h0000);
    idle(1);
  endtask
  // two control writes with nothing between, then settle
  task automatic launch(input logic [7:0] a, input logic [7:0] b);
    ctl(a);
    ctl(b);
    idle(3);
  endtask
  // bounded wait for the busy flag
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (program_busy_flag !== lvl && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (program_busy_flag !== lvl) begin
      check("busy wait", {15'h0000, lvl}, {15'h0000, program_busy_flag});
      results();
    end
  endtask
  // compare each answer on the command port with the oldest note
  always @(posedge mclk) begin
    if (rd_pend && exp_q.size() > 0) begin
      check(name_q.pop_front(), exp_q.pop_front(), cmd_rdata);
    end
    rd_pend = cmd_rd;
    if (bus_if.code_boot_hit) begin
      hit_seen = 1'b1;
    end
  end
  // main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($random(seed));
    end
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    expect_rd("control reset", OP_SFR_READ, 16'h00d1, FLASH_CONTROL_RST);
    check("prog disable", 16'h1, {15'h0, parallel_prog_disable});
    check("verify disable", 16'h1, {15'h0, parallel_verify_disable});
    ctl(8'h04);
    expect_rd("security byte", OP_CODE_READ, 16'h0000, SECURITY_RST);
    $display("test reset state done");
    host(1'b1, HOST_CTRL, 16'h0001);
    ctl(8'h08);
    op(OP_DATA_WRITE, ra[0], v[0]);
    launch(8'h50, 8'ha0);
    check("busy after launch", 16'h1, {15'h0, program_busy_flag});
    ctl(8'h08);
    expect_rd("control while busy", OP_SFR_READ, 16'h00d1, 8'h09);
    wait_busy(1'b0);
    ctl(8'h00);
    op(OP_DATA_WRITE, ra[0], ~v[0]);
    ctl(8'h08);
    op(OP_DATA_WRITE, 16'h0283, v[1]);
    op(OP_DATA_WRITE, ra[2], v[2]);
    op(OP_DATA_WRITE, ra[3], v[3]);
    launch(8'h50, 8'ha0);
    wait_busy(1'b0);
    ctl(8'h00);
    for (int i = 0; i < 4; i++) begin
      expect_rd("user cell", OP_CODE_READ, ra[i], v[i]);
    end
    $display("test user program done");
    ctl(8'h08);
    op(OP_DATA_WRITE, 16'h0384, 8'h3c);
    for (int i = 0; i < 5; i++) begin
      host(1'b1, HOST_CTRL, (i == 4) ? 16'h0000 : 16'h0001);
      ctl(f1[i]);
      if (i == 0) begin
        op(OP_CODE_READ, 16'h0000, 8'h00);
      end
      ctl(f2[i]);
      idle(3);
      check("busy after bad unlock", 16'h0, {15'h0, program_busy_flag});
    end
    host(1'b1, HOST_CTRL, 16'h0001);
    launch(8'h50, 8'ha0);
    wait_busy(1'b0);
    ctl(8'h00);
    expect_rd("kept latch", OP_CODE_READ, 16'h0384, 8'h3c);
    $display("test unlock faults done");
    ctl(8'h08);
    op(OP_DATA_WRITE, 16'hff85, v[1]);
    launch(8'h52, 8'ha2);
    wait_busy(1'b0);
    ctl(8'h02);
    expect_rd("extra row", OP_CODE_READ, 16'hff85, v[1]);
    ctl(8'h0c);
    op(OP_DATA_WRITE, 16'h0000, v[2]);
    launch(8'h54, 8'ha4);
    wait_busy(1'b0);
    ctl(8'h04);
    expect_rd("security prog", OP_CODE_READ, 16'h0000, {v[2][7:4], SECURITY_RST[3:0]});
    check("prog disable kept", 16'h1, {15'h0, parallel_prog_disable});
    $display("test extra row and security done");
    host(1'b1, HOST_CTRL, 16'h0006);
    ctl(8'h00);
    idle(2);
    check("eeprom select", 16'h1, {15'h0, eeprom_select});
    ctl(8'h08);
    idle(2);
    check("latch map wins", 16'h0, {15'h0, eeprom_select});
    ctl(8'h00);
    hit_seen = 1'b0;
    op(OP_CODE_READ, 16'hf900, 8'h00);
    idle(3);
    check("boot flash hit", 16'h1, {15'h0, hit_seen});
    $display("test mapping done");
    idle(2);
    results();
  end
endmodule
`default_nettype wire
